//--- csr_params.svh
// Register offsets, field positions, reset values for status/core control
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH
`define OFF_STATUS      4'h0
`define OFF_CORE_CTL    4'h4
`define OFF_LOOP_EVT    4'h8
`define POS_PRI_HI      7
`define POS_PRI_LO      5
`define POS_RPT         4
`define POS_NEG         3
`define POS_OVF         2
`define POS_ZERO        1
`define POS_CARRY       0
`define POS_HIST_A      13
`define POS_HIST_B      12
`define POS_HIST_ANY    10
`define POS_VAR         15
`define POS_USGN        12
`define POS_EDT         11
`define POS_DL_HI       10
`define POS_DL_LO       8
`define POS_ACC_A_CLIP_EN        7
`define POS_ACC_B_CLIP_EN        6
`define POS_DSP_WRITE_CLIP_EN       5
`define POS_CLIP_MODE_SEL      4
`define POS_PTOP        3
`define POS_PSV         2
`define POS_RND         1
`define POS_IF          0
`define RST_STATUS      16'h0000
`define RST_CORE_CTL    16'h0020
`define CTL_WR_MASK     16'h90F7
`endif

//--- csr_pkg.sv
// Types shared by the status and core control register block
`default_nettype none
package csr_pkg;
	typedef struct packed {
		logic        valid;
		logic        negative;
		logic        wrap;
		logic        zero;
		logic        carry;
	} alu_flags_s;
	typedef struct packed {
		logic        a_clip;
		logic        b_clip;
	} acc_clip_s;
	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_ACK
	} bus_state_e;
endpackage : csr_pkg
`default_nettype wire

//--- cpu_status_core_control_regs.sv
// Processor status and core control register bank on Avalon-MM
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "csr_params.svh"
`default_nettype none

// Contract
// - Status bits 7:5 hold three-bit priority, level 7 blocks user interrupts.
// - Effective priority is top bit over low bits; top bit blocks users.
// - Low priority bits ignore writes while nesting disable is set.
// - Repeat-active bit 4 follows the running repeat loop.
// - Negative bit 3 follows the sign of the ALU result.
// - Overflow bit 2 flags signed two's complement overflow.
// - Zero bit 1 set when ALU result is zero.
// - Carry bit 0 set on carry out of the result MSb.
// - Status write sets clip history only with combined bit also set; combined bit zero clears both.
// - Top priority bit is readable and clearable, never set by software.
// - Top priority bit shows trap activity, priority 8 or above.
// - Program-space window enable bit 2 maps program memory into data.
// - Control bit 15 selects variable or fixed exception latency.
// - Stack frame active makes frame and stack pointers flat 16-bit.
// - Unimplemented control bits read zero and ignore writes.
// - Control bit 12 selects unsigned multiplies, else signed.
// - Writing 1 to bit 11 ends loop after iteration; reads zero.
// - Bits 10:8 report loop nesting depth; upper two read-only.
// - First two loop nesting levels kept in hardware context.
// - Bits 7,6,5 enable clipping of A, B and DSP writes.
// - Bit 4 selects 9.31 super or 1.31 normal saturation.
// - Bit 1 selects biased rounding; bit 0 selects integer multiply.
// - Clip history sticks until cleared; combined clear clears both.
module cpu_status_core_control_regs
	import csr_pkg::*;
(
	input  wire logic        CLK,              // Core clock, 25 MHz
	input  wire logic        RST_N,            // Async reset, active low
	input  wire logic [3:0]  AVS_ADDRESS,      // Byte address
	input  wire logic        AVS_READ,         // Read request
	input  wire logic        AVS_WRITE,        // Write request
	input  wire logic [31:0] AVS_WRITEDATA,    // Write data
	input  wire logic [3:0]  AVS_BYTEENABLE,   // Byte lanes
	output logic [31:0]      AVS_READDATA,     // Read data
	output logic             AVS_WAITREQUEST,  // Stall
	output logic [1:0]       AVS_RESPONSE,     // 00 ok, 10 slave error
	input  wire alu_flags_s  ALU_FLAGS,        // ALU result flags update
	input  wire logic        REPEAT_RUN,       // Repeat loop executing
	input  wire acc_clip_s   ACC_CLIP,         // Accumulator saturated now
	input  wire logic        NESTING_DISABLE_CTL, // Nesting disable control
	input  wire logic        TRAP_ENTER,       // Trap taken, priority >= 8
	input  wire logic        TRAP_PRI_SET,     // Exception unit loads priority
	input  wire logic [2:0]  TRAP_PRI_VAL,     // Priority value to load
	input  wire logic        LOOP_PUSH,        // Hardware loop entered
	input  wire logic        LOOP_POP,         // Hardware loop finished
	input  wire logic        STACK_FRAME_SET,  // Stack frame becomes active
	input  wire logic        STACK_FRAME_CLR,  // Stack frame ends
	output logic [3:0]       CPU_PRIORITY,     // Effective four-bit priority
	output logic             USER_IRQ_BLOCK,   // User interrupts blocked
	output logic             PROGSPACE_WINDOW_EN, // Program memory mapped
	output logic             VAR_LATENCY,      // Variable exception latency
	output logic             FLAT_POINTER_ADDR,// Frame/stack pointers flat
	output logic             MULTIPLY_UNSIGNED_SEL, // Unsigned multiply
	output logic             EARLY_LOOP_TERMINATE, // End loop pulse
	output logic [2:0]       LOOP_NEST_LEVEL,  // Loop nesting depth
	output logic             HW_LOOP_CONTEXT,  // Depth held in hw context
	output logic             ACC_A_CLIP_EN,    // Clip accumulator A
	output logic             ACC_B_CLIP_EN,    // Clip accumulator B
	output logic             DSP_WRITE_CLIP_EN,// Clip DSP data writes
	output logic             CLIP_MODE_SEL,    // 1: 9.31, 0: 1.31
	output logic             ROUND_MODE_SEL,   // 1: biased rounding
	output logic             INTEGER_MODE_SEL  // 1: integer multiply
);

	logic [2:0]  pri_low_r;
	logic        rpt_r;
	logic        neg_r;
	logic        ovf_r;
	logic        zero_r;
	logic        carry_r;
	logic        hist_a_r;
	logic        hist_b_r;
	logic        pri_top_r;
	logic [15:0] ctl_r;
	logic [2:0]  nest_r;
	logic        sfa_r;
	logic        edt_r;
	logic        ack_r;
	logic [31:0] rdata_r;
	logic        err_r;
	logic [15:0] wdat;
	logic [15:0] cpu_status_reg;
	logic [15:0] core_control_reg;
	logic        wr_stat;
	logic        wr_ctl;
	logic        hit;
	logic        req_new;
	logic [2:0]  sel;

	// Merge byte enables over a 16-bit old value
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] be);
		merge16 = {be[1] ? nw[15:8] : old[15:8],
			be[0] ? nw[7:0] : old[7:0]};
	endfunction : merge16

	// Register select: one-hot over status, control and the reserved slot
	function automatic logic [2:0] reg_select(input logic [3:0] addr);
		logic [2:0] onehot;
		onehot = 3'h0;
		case (addr)
			`OFF_STATUS:   onehot = 3'h1;
			`OFF_CORE_CTL: onehot = 3'h2;
			`OFF_LOOP_EVT: onehot = 3'h4;
			default:       onehot = 3'h0;
		endcase
		return onehot;
	endfunction : reg_select

	// Address decode; a write takes effect on the acknowledge edge only,
	// so a stalled request can never write twice
	assign sel = reg_select(AVS_ADDRESS);
	assign hit = |sel;
	assign req_new = (AVS_READ || AVS_WRITE) && !ack_r;
	assign wr_stat = AVS_WRITE && ack_r && sel[0];
	assign wr_ctl = AVS_WRITE && ack_r && sel[1];

	// Status image; the combined history bit is an OR, not storage,
	// so clearing it can only act through the history write path
	always_comb
	begin
		cpu_status_reg = 16'h0000;
		cpu_status_reg[`POS_HIST_A] = hist_a_r;
		cpu_status_reg[`POS_HIST_B] = hist_b_r;
		cpu_status_reg[`POS_HIST_ANY] = hist_a_r | hist_b_r;
		cpu_status_reg[`POS_PRI_HI:`POS_PRI_LO] = pri_low_r;
		cpu_status_reg[`POS_RPT] = rpt_r;
		cpu_status_reg[`POS_NEG] = neg_r;
		cpu_status_reg[`POS_OVF] = ovf_r;
		cpu_status_reg[`POS_ZERO] = zero_r;
		cpu_status_reg[`POS_CARRY] = carry_r;
	end

	// Control image; unused positions and the terminate bit read zero
	always_comb
	begin
		core_control_reg = 16'h0000;
		core_control_reg[`POS_VAR] = ctl_r[`POS_VAR];
		core_control_reg[`POS_USGN] = ctl_r[`POS_USGN];
		core_control_reg[`POS_DL_HI:`POS_DL_LO] = nest_r;
		core_control_reg[`POS_ACC_A_CLIP_EN] = ctl_r[`POS_ACC_A_CLIP_EN];
		core_control_reg[`POS_ACC_B_CLIP_EN] = ctl_r[`POS_ACC_B_CLIP_EN];
		core_control_reg[`POS_DSP_WRITE_CLIP_EN] = ctl_r[`POS_DSP_WRITE_CLIP_EN];
		core_control_reg[`POS_CLIP_MODE_SEL] = ctl_r[`POS_CLIP_MODE_SEL];
		core_control_reg[`POS_PTOP] = pri_top_r;
		core_control_reg[`POS_PSV] = ctl_r[`POS_PSV];
		core_control_reg[`POS_RND] = ctl_r[`POS_RND];
		core_control_reg[`POS_IF] = ctl_r[`POS_IF];
	end

	// Lanes the master did not enable keep the current image
	assign wdat = merge16(sel[0] ? cpu_status_reg : core_control_reg,
		AVS_WRITEDATA[15:0], AVS_BYTEENABLE[1:0]);

	// One wait state per access: acknowledge the cycle after a request
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ack_r <= 1'b0;
		end
		else
		begin
			ack_r <= req_new;
		end
	end

	// Unmapped addresses answer with an error response
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			err_r <= 1'b0;
		end
		else if (req_new)
		begin
			err_r <= !hit;
		end
	end

	// Read data is captured on the request edge, so it stands at the
	// acknowledge edge and until the next access is taken
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rdata_r <= 32'h0000_0000;
		end
		else if (req_new)
		begin
			case (sel)
				3'h1:    rdata_r <= {16'h0000, cpu_status_reg};
				3'h2:    rdata_r <= {16'h0000, core_control_reg};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// Stall is combinational so the first request cycle is held at once
	assign AVS_WAITREQUEST = req_new;
	assign AVS_READDATA = rdata_r;
	assign AVS_RESPONSE = err_r ? 2'b10 : 2'b00;

	// ALU flags: hardware update beats a software write in the same cycle
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			{neg_r, ovf_r, zero_r, carry_r} <= 4'h0;
		else if (ALU_FLAGS.valid)
		begin
			neg_r   <= ALU_FLAGS.negative;
			ovf_r   <= ALU_FLAGS.wrap;
			zero_r  <= ALU_FLAGS.zero;
			carry_r <= ALU_FLAGS.carry;
		end
		else if (wr_stat)
			{neg_r, ovf_r, zero_r, carry_r} <= wdat[3:0];
	end

	// Repeat-active mirrors the sequencer, read-only
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rpt_r <= 1'b0;
		end
		else
		begin
			rpt_r <= REPEAT_RUN;
		end
	end

	// Low priority bits; exception unit load has precedence
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pri_low_r <= 3'h0;
		end
		else if (TRAP_PRI_SET)
		begin
			pri_low_r <= TRAP_PRI_VAL;
		end
		else if (wr_stat && !NESTING_DISABLE_CTL)
		begin
			pri_low_r <= wdat[`POS_PRI_HI:`POS_PRI_LO];
		end
	end

	// Clip history: set wins over clear; clearing combined clears both
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			hist_a_r <= 1'b0;
			hist_b_r <= 1'b0;
		end
		else
		begin
			if (ACC_CLIP.a_clip)
				hist_a_r <= 1'b1;
			else if (wr_stat)
				hist_a_r <= wdat[`POS_HIST_A] &
					wdat[`POS_HIST_ANY];
			if (ACC_CLIP.b_clip)
				hist_b_r <= 1'b1;
			else if (wr_stat)
				hist_b_r <= wdat[`POS_HIST_B] &
					wdat[`POS_HIST_ANY];
		end
	end

	// Top priority bit: set by trap entry, software may only clear
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pri_top_r <= 1'b0;
		end
		else if (TRAP_ENTER)
		begin
			pri_top_r <= 1'b1;
		end
		else if (wr_ctl && !wdat[`POS_PTOP])
		begin
			pri_top_r <= 1'b0;
		end
	end

	// Writable control bits; masked positions stay zero
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ctl_r <= `RST_CORE_CTL;
		end
		else if (wr_ctl)
		begin
			ctl_r <= wdat & `CTL_WR_MASK;
		end
	end

	// Early terminate: one-cycle pulse, never stored for readback
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			edt_r <= 1'b0;
		end
		else
		begin
			edt_r <= wr_ctl && wdat[`POS_EDT];
		end
	end

	// Loop depth counter; software may only write the low bit
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			nest_r <= 3'h0;
		end
		else if (LOOP_PUSH && !LOOP_POP && nest_r != 3'h7)
		begin
			nest_r <= nest_r + 3'h1;
		end
		else if (LOOP_POP && !LOOP_PUSH && nest_r != 3'h0)
		begin
			nest_r <= nest_r - 3'h1;
		end
		else if (wr_ctl)
		begin
			nest_r <= {nest_r[2:1], wdat[`POS_DL_LO]};
		end
	end

	// Stack frame status, hardware owned
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sfa_r <= 1'b0;
		end
		else if (STACK_FRAME_SET)
		begin
			sfa_r <= 1'b1;
		end
		else if (STACK_FRAME_CLR)
		begin
			sfa_r <= 1'b0;
		end
	end

	// Control outputs to core, datapath and address generator
	assign CPU_PRIORITY = {pri_top_r, pri_low_r};
	assign USER_IRQ_BLOCK = pri_top_r || (pri_low_r == 3'h7);
	assign PROGSPACE_WINDOW_EN = ctl_r[`POS_PSV];
	assign VAR_LATENCY = ctl_r[`POS_VAR];
	assign FLAT_POINTER_ADDR = sfa_r;
	assign MULTIPLY_UNSIGNED_SEL = ctl_r[`POS_USGN];
	assign EARLY_LOOP_TERMINATE = edt_r;
	assign LOOP_NEST_LEVEL = nest_r;
	// Depths one and two need no software context save
	assign HW_LOOP_CONTEXT = (nest_r != 3'h0) && (nest_r <= 3'h2);
	assign ACC_A_CLIP_EN = ctl_r[`POS_ACC_A_CLIP_EN];
	assign ACC_B_CLIP_EN = ctl_r[`POS_ACC_B_CLIP_EN];
	assign DSP_WRITE_CLIP_EN = ctl_r[`POS_DSP_WRITE_CLIP_EN];
	assign CLIP_MODE_SEL = ctl_r[`POS_CLIP_MODE_SEL];
	assign ROUND_MODE_SEL = ctl_r[`POS_RND];
	assign INTEGER_MODE_SEL = ctl_r[`POS_IF];

endmodule : cpu_status_core_control_regs
`default_nettype wire

//--- cpu_status_core_control_regs_asserts.sv
// Concurrent checks for the status and core control register block
`timescale 1ns/1ps
`default_nettype none
module csr_asserts
	import csr_pkg::*;
(
	input wire logic       CLK,                  // Clock
	input wire logic       RST_N,                // Reset, active low
	input wire logic       NESTING_DISABLE_CTL,  // Priority lock
	input wire logic       TRAP_ENTER,           // Trap taken
	input wire logic       TRAP_PRI_SET,         // Priority load
	input wire logic [2:0] TRAP_PRI_VAL,         // Priority value
	input wire logic       LOOP_PUSH,            // Loop entered
	input wire logic       LOOP_POP,             // Loop left
	input wire logic [3:0] CPU_PRIORITY,         // Effective priority
	input wire logic       USER_IRQ_BLOCK,       // User block
	input wire logic       EARLY_LOOP_TERMINATE, // Loop end pulse
	input wire logic [2:0] LOOP_NEST_LEVEL,      // Loop depth
	input wire logic       HW_LOOP_CONTEXT       // Depth in hardware
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	irq_block_a:
		assert property (USER_IRQ_BLOCK ==
			(CPU_PRIORITY[3] || CPU_PRIORITY[2:0] == 3'h7))
		else $error("user block disagrees with priority");
	// Software may only clear the top bit, so a rise needs a trap
	top_no_set_a:
		assert property ($rose(CPU_PRIORITY[3]) |-> $past(TRAP_ENTER))
		else $error("top priority bit rose without a trap");
	trap_top_a:
		assert property (TRAP_ENTER |=> CPU_PRIORITY[3])
		else $error("trap did not set top priority bit");
	pri_lock_a:
		assert property (NESTING_DISABLE_CTL && !TRAP_PRI_SET
			|=> $stable(CPU_PRIORITY[2:0]))
		else $error("locked priority changed");
	pri_load_a:
		assert property (TRAP_PRI_SET
			|=> CPU_PRIORITY[2:0] == $past(TRAP_PRI_VAL))
		else $error("priority load lost");
	edt_pulse_a:
		assert property (EARLY_LOOP_TERMINATE |=> !EARLY_LOOP_TERMINATE)
		else $error("loop end pulse too long");
	push_level_a:
		assert property (LOOP_PUSH && !LOOP_POP && LOOP_NEST_LEVEL != 3'h7
			|=> LOOP_NEST_LEVEL == $past(LOOP_NEST_LEVEL) + 3'h1)
		else $error("loop depth did not count up");
	loop_ctx_a:
		assert property (HW_LOOP_CONTEXT ==
			(LOOP_NEST_LEVEL inside {3'h1, 3'h2}))
		else $error("hardware loop context wrong");
endmodule : csr_asserts

bind cpu_status_core_control_regs csr_asserts u_csr_asserts (.CLK, .RST_N,
	.NESTING_DISABLE_CTL, .TRAP_ENTER, .TRAP_PRI_SET, .TRAP_PRI_VAL,
	.LOOP_PUSH, .LOOP_POP, .CPU_PRIORITY, .USER_IRQ_BLOCK,
	.EARLY_LOOP_TERMINATE, .LOOP_NEST_LEVEL, .HW_LOOP_CONTEXT);
`default_nettype wire

//--- test_cpu_status_core_control_regs.sv
// Self-checking bench for the status and core control register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin \
	mismatches++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module test_cpu_status_core_control_regs
	import csr_pkg::*;
;
	logic CLK = 1'b0, RST_N = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
	logic REPEAT_RUN = 1'b0, NESTING_DISABLE_CTL = 1'b0, TRAP_ENTER = 1'b0;
	logic TRAP_PRI_SET = 1'b0, LOOP_PUSH = 1'b0, LOOP_POP = 1'b0;
	logic STACK_FRAME_SET = 1'b0, STACK_FRAME_CLR = 1'b0;
	logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hF, CPU_PRIORITY;
	logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA;
	logic [2:0] TRAP_PRI_VAL = 3'h0, LOOP_NEST_LEVEL;
	logic [1:0] AVS_RESPONSE;
	alu_flags_s ALU_FLAGS = '0;
	acc_clip_s ACC_CLIP = '0;
	logic AVS_WAITREQUEST, USER_IRQ_BLOCK, PROGSPACE_WINDOW_EN, VAR_LATENCY;
	logic FLAT_POINTER_ADDR, MULTIPLY_UNSIGNED_SEL, EARLY_LOOP_TERMINATE;
	logic HW_LOOP_CONTEXT, ACC_A_CLIP_EN, ACC_B_CLIP_EN, DSP_WRITE_CLIP_EN;
	logic CLIP_MODE_SEL, ROUND_MODE_SEL, INTEGER_MODE_SEL;
	int mismatches = 0, tests_run = 0, cyc = 0, edts = 0, tn = 0;
	logic [33:0] exp_q[$];
	logic [15:0] d;
	logic [33:0] exp_w;
	cpu_status_core_control_regs u_cpu_status_core_control_regs (.CLK,
		.RST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
		.AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .AVS_RESPONSE,
		.ALU_FLAGS, .REPEAT_RUN, .ACC_CLIP, .NESTING_DISABLE_CTL, .TRAP_ENTER,
		.TRAP_PRI_SET, .TRAP_PRI_VAL, .LOOP_PUSH, .LOOP_POP, .STACK_FRAME_SET,
		.STACK_FRAME_CLR, .CPU_PRIORITY, .USER_IRQ_BLOCK, .PROGSPACE_WINDOW_EN,
		.VAR_LATENCY, .FLAT_POINTER_ADDR, .MULTIPLY_UNSIGNED_SEL,
		.EARLY_LOOP_TERMINATE, .LOOP_NEST_LEVEL, .HW_LOOP_CONTEXT,
		.ACC_A_CLIP_EN, .ACC_B_CLIP_EN, .DSP_WRITE_CLIP_EN, .CLIP_MODE_SEL,
		.ROUND_MODE_SEL, .INTEGER_MODE_SEL);
	// 25 MHz clock
	initial forever #20 CLK = ~CLK;
	// Read checker and watchdog; well above the few hundred cycles used
	always @(posedge CLK)
	begin
		cyc++;
		if (AVS_READ && !AVS_WAITREQUEST)
		begin
			exp_w = exp_q.pop_front();
			`CHK({AVS_RESPONSE, AVS_READDATA}, exp_w)
		end
		if (cyc == 4000)
		begin
			mismatches++;
			summarize();
		end
	end
	// Pulse counter on the falling edge, away from the main sequence
	always @(negedge CLK) edts += EARLY_LOOP_TERMINATE;
	task summarize;
		$display("tests %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	// One bus access; a read notes its expected response and data
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [15:0] v);
		if (!w) exp_q.push_back({(a == 4'hC) ? 2'b10 : 2'b00, 16'h0, v});
		AVS_ADDRESS <= a;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_WRITEDATA <= {16'h0, v};
		do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge CLK);
	endtask : bus
	// Push or pop n loop levels, one pulse every two cycles
	task automatic lp(input logic p, input int n);
		repeat (n)
		begin
			LOOP_PUSH <= p;
			LOOP_POP <= !p;
			@(posedge CLK);
			LOOP_PUSH <= 1'b0;
			LOOP_POP <= 1'b0;
			@(posedge CLK);
		end
	endtask : lp
	task nx;
		tn++;
		$display("test %0d end", tn);
	endtask : nx
	// Main sequence
	initial
	begin
		d = 16'($urandom(97090));
		repeat (3) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		bus(0, 4'h0, 16'h0000);
		bus(0, 4'h4, 16'h0020);
		nx();
		repeat (6)
		begin
			d = 16'($urandom) & 16'h001F;
			REPEAT_RUN <= d[4];
			ALU_FLAGS <= {1'b1, d[3:0]};
			@(posedge CLK);
			ALU_FLAGS <= '0;
			bus(0, 4'h0, d);
		end
		REPEAT_RUN <= 1'b0;
		nx();
		bus(1, 4'h0, 16'h00E0);
		bus(0, 4'h0, 16'h00E0);
		`CHK(USER_IRQ_BLOCK, 1'b1)
		NESTING_DISABLE_CTL <= 1'b1;
		bus(1, 4'h0, 16'h0040);
		bus(0, 4'h0, 16'h00E0);
		TRAP_PRI_SET <= 1'b1;
		TRAP_PRI_VAL <= 3'h3;
		@(posedge CLK);
		TRAP_PRI_SET <= 1'b0;
		NESTING_DISABLE_CTL <= 1'b0;
		bus(0, 4'h0, 16'h0060);
		nx();
		ACC_CLIP <= 2'b10;
		@(posedge CLK);
		ACC_CLIP <= '0;
		bus(0, 4'h0, 16'h2460);
		bus(1, 4'h0, 16'h3060);
		bus(0, 4'h0, 16'h0060);
		bus(1, 4'h0, 16'h3400);
		bus(0, 4'h0, 16'h3400);
		nx();
		TRAP_ENTER <= 1'b1;
		@(posedge CLK);
		TRAP_ENTER <= 1'b0;
		bus(0, 4'h4, 16'h0028);
		`CHK(CPU_PRIORITY, 4'h8)
		bus(1, 4'h4, 16'h0020);
		bus(0, 4'h4, 16'h0020);
		bus(1, 4'h4, 16'h0028);
		bus(0, 4'h4, 16'h0020);
		nx();
		repeat (6)
		begin
			d = 16'($urandom);
			bus(1, 4'h4, d);
			bus(0, 4'h4, d & 16'h91F7);
			`CHK(VAR_LATENCY, d[15])
			`CHK(MULTIPLY_UNSIGNED_SEL, d[12])
			`CHK(ACC_A_CLIP_EN, d[7])
			`CHK(ACC_B_CLIP_EN, d[6])
			`CHK(DSP_WRITE_CLIP_EN, d[5])
			`CHK(CLIP_MODE_SEL, d[4])
			`CHK(PROGSPACE_WINDOW_EN, d[2])
			`CHK(ROUND_MODE_SEL, d[1])
			`CHK(INTEGER_MODE_SEL, d[0])
		end
		edts = 0;
		bus(1, 4'h4, 16'h0800);
		@(posedge CLK);
		`CHK(edts, 1)
		nx();
		bus(1, 4'h4, 16'h0000);
		lp(1, 8);
		bus(0, 4'h4, 16'h0700);
		lp(0, 6);
		`CHK(HW_LOOP_CONTEXT, 1'b1)
		lp(0, 2);
		bus(0, 4'h4, 16'h0000);
		nx();
		STACK_FRAME_SET <= 1'b1;
		@(posedge CLK);
		STACK_FRAME_SET <= 1'b0;
		@(posedge CLK);
		`CHK(FLAT_POINTER_ADDR, 1'b1)
		STACK_FRAME_CLR <= 1'b1;
		@(posedge CLK);
		STACK_FRAME_CLR <= 1'b0;
		@(posedge CLK);
		`CHK(FLAT_POINTER_ADDR, 1'b0)
		// Low lane only: the upper byte of the write must be dropped
		AVS_BYTEENABLE <= 4'h1;
		bus(1, 4'h4, 16'hFFB0);
		AVS_BYTEENABLE <= 4'hF;
		bus(0, 4'h4, 16'h00B0);
		bus(1, 4'hC, 16'hFFFF);
		bus(0, 4'hC, 16'h0000);
		bus(0, 4'h8, 16'h0000);
		nx();
		summarize();
	end
endmodule : test_cpu_status_core_control_regs
`default_nettype wire
